// ===== rtl/tcp_top.sv
`timescale 1ns/1ps
module tcp_top
  import tcp_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [1:0]        chan_pin_out,
  output logic      [1:0]        chan_pin_oe,
  output logic      [1:0]        chan_irq,
  output logic                   wrap_irq
);
  `include "tcp_consts.svh"

  if (ADDR_W < 8) begin : g_chk
    $error("tcp_top: ADDR_W must be at least 8");
  end

  logic             wrap_flag_reg;
  logic             wrap_armed_reg;
  logic             wrap_ie_reg;
  logic             halt_reg;
  logic [2:0]       div_sel_reg;
  tcp_count_t       limit_reg;
  tcp_count_t       cnt_reg;
  tcp_cfg_t         cfg_reg   [2];
  logic [1:0]       ch_flag_reg;
  logic [1:0]       ch_armed_reg;
  tcp_count_t       val_reg   [2];
  logic             active_sel_reg;
  logic             last_sel_reg;
  logic             last_sel_next;
  logic [31:0]      prdata_reg;
  logic [31:0]      rd_mux;

  logic             wr;
  logic             rd_setup;
  logic             hit;
  logic             tick;
  logic             run;
  logic             at_limit;
  tcp_count_t       cnt_step;
  logic             wrap_ev;
  logic             cnt_clear;
  logic             linked;
  logic             link_on;
  logic [1:0]       oc_en;
  logic [1:0]       match;
  tcp_count_t       cmp_val   [2];

  function automatic logic at_off(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    at_off = (a[ADDR_W-1:0] == ADDR_W'(off));
  endfunction

  function automatic logic [11:0] ch_ctrl_off(input int i);
    ch_ctrl_off = 12'(`TCP_OFF_CH0_CTRL + i * `TCP_OFF_STRIDE);
  endfunction

  function automatic logic [11:0] ch_val_off(input int i);
    ch_val_off = 12'(`TCP_OFF_CH0_VALUE + i * `TCP_OFF_STRIDE);
  endfunction

  // APB slave, zero wait states
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit      = at_off(paddr, `TCP_OFF_TIMER) || at_off(paddr, `TCP_OFF_COUNT) ||
                    at_off(paddr, `TCP_OFF_LIMIT) || at_off(paddr, ch_ctrl_off(0)) ||
                    at_off(paddr, ch_val_off(0)) || at_off(paddr, ch_ctrl_off(1)) ||
                    at_off(paddr, ch_val_off(1));
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (at_off(paddr, `TCP_OFF_TIMER))
      rd_mux = {24'h00_0000, wrap_flag_reg, wrap_ie_reg, halt_reg, 2'h0, div_sel_reg};
    else if (at_off(paddr, `TCP_OFF_COUNT))
      rd_mux = {16'h0000, cnt_reg};
    else if (at_off(paddr, `TCP_OFF_LIMIT))
      rd_mux = {16'h0000, limit_reg};
    else if (at_off(paddr, ch_ctrl_off(0)))
      rd_mux = {24'h00_0000, ch_flag_reg[0], cfg_reg[0]};
    else if (at_off(paddr, ch_val_off(0)))
      rd_mux = {16'h0000, val_reg[0]};
    else if (at_off(paddr, ch_ctrl_off(1)))
      rd_mux = {24'h00_0000, ch_flag_reg[1], cfg_reg[1]};
    else if (at_off(paddr, ch_val_off(1)))
      rd_mux = {16'h0000, val_reg[1]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (rd_setup)
      prdata_reg <= rd_mux;
  end

  assign prdata = prdata_reg;

  // Timer control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wrap_ie_reg <= 1'b0;
      halt_reg    <= `TCP_RST_HALT;
      div_sel_reg <= `TCP_RST_DIV;
    end
    else if (wr && at_off(paddr, `TCP_OFF_TIMER))
    begin
      wrap_ie_reg <= pwdata[`TCP_TC_IE];
      halt_reg    <= pwdata[`TCP_TC_HALT];
      div_sel_reg <= pwdata[`TCP_TC_DIV_MSB:`TCP_TC_DIV_LSB];
    end
  end

  assign cnt_clear = wr && at_off(paddr, `TCP_OFF_TIMER) && pwdata[`TCP_TC_RST];

  tcp_prescaler #(
    .DIV_BITS (6)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (cnt_clear),
    .sel     (div_sel_reg),
    .tick    (tick)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      limit_reg <= `TCP_RST_LIMIT;
    else if (wr && at_off(paddr, `TCP_OFF_LIMIT))
      limit_reg <= pwdata[15:0];
  end

  // Counter
  assign run      = tick && !halt_reg;
  assign at_limit = (cnt_reg == limit_reg);
  assign wrap_ev  = run && at_limit;
  // Count value this tick moves to
  assign cnt_step = at_limit ? `TCP_CNT_ZERO : cnt_reg + `TCP_CNT_ONE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= `TCP_CNT_ZERO;
    else if (cnt_clear)
      cnt_reg <= `TCP_CNT_ZERO;
    else if (wrap_ev)
      cnt_reg <= `TCP_CNT_ZERO;
    else if (run)
      cnt_reg <= cnt_reg + `TCP_CNT_ONE;
  end

  // Wrap flag, cleared by read while set then write of zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wrap_flag_reg  <= 1'b0;
      wrap_armed_reg <= 1'b0;
    end
    else if (wrap_ev)
    begin
      wrap_flag_reg  <= 1'b1;
      wrap_armed_reg <= 1'b0;
    end
    else if (wr && at_off(paddr, `TCP_OFF_TIMER))
    begin
      if (wrap_armed_reg && !pwdata[`TCP_TC_FLAG])
        wrap_flag_reg <= 1'b0;
      wrap_armed_reg <= 1'b0;
    end
    else if (rd_setup && at_off(paddr, `TCP_OFF_TIMER) && wrap_flag_reg)
      wrap_armed_reg <= 1'b1;
  end

  assign wrap_irq = wrap_flag_reg && wrap_ie_reg;

  // Pairing and active value set
  assign linked  = cfg_reg[0][`TCP_CC_MODE_B];
  assign link_on = wr && at_off(paddr, ch_ctrl_off(0)) && pwdata[`TCP_CC_MODE_B] && !linked;

  always_comb
  begin
    last_sel_next = last_sel_reg;
    if (link_on)
      last_sel_next = 1'b0;
    else if (wr && at_off(paddr, ch_val_off(0)))
      last_sel_next = 1'b0;
    else if (wr && at_off(paddr, ch_val_off(1)))
      last_sel_next = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_sel_reg   <= 1'b0;
      active_sel_reg <= 1'b0;
    end
    else
    begin
      last_sel_reg <= last_sel_next;
      if (link_on)
        active_sel_reg <= 1'b0;
      else if (linked && wrap_ev)
        active_sel_reg <= last_sel_next;
    end
  end

  assign cmp_val[0] = (linked && active_sel_reg) ? val_reg[1] : val_reg[0];
  assign cmp_val[1] = val_reg[1];

  // Per-channel registers and pin logic
  tcp_chan_if chif [2] ();

  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cfg_reg[i] <= `TCP_RST_CFG;
        val_reg[i] <= `TCP_RST_VALUE;
      end
      else
      begin
        if (wr && at_off(paddr, ch_ctrl_off(i)))
          cfg_reg[i] <= pwdata[6:0];
        if (wr && at_off(paddr, ch_val_off(i)))
          val_reg[i] <= pwdata[15:0];
      end
    end

    assign oc_en[i] = (cfg_reg[i][`TCP_CC_MODE_B:`TCP_CC_MODE_A] != `TCP_MODE_OFF) &&
                      ((i == 0) || !linked);
    assign match[i] = run && oc_en[i] && (cnt_step == cmp_val[i]);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ch_flag_reg[i]  <= 1'b0;
        ch_armed_reg[i] <= 1'b0;
      end
      else if (match[i])
      begin
        ch_flag_reg[i]  <= 1'b1;
        ch_armed_reg[i] <= 1'b0;
      end
      else if (wr && at_off(paddr, ch_ctrl_off(i)))
      begin
        if (ch_armed_reg[i] && !pwdata[`TCP_CC_FLAG])
          ch_flag_reg[i] <= 1'b0;
        ch_armed_reg[i] <= 1'b0;
      end
      else if (rd_setup && at_off(paddr, ch_ctrl_off(i)) && ch_flag_reg[i])
        ch_armed_reg[i] <= 1'b1;
    end

    assign chan_irq[i] = ch_flag_reg[i] && cfg_reg[i][`TCP_CC_IE];

    assign chif[i].tick   = run;
    assign chif[i].wrap   = wrap_ev && oc_en[i];
    assign chif[i].match  = match[i];
    assign chif[i].enable = oc_en[i];
    assign chif[i].tov    = cfg_reg[i][`TCP_CC_TOV];
    assign chif[i].fmax   = cfg_reg[i][`TCP_CC_MAX];
    assign chif[i].act    = tcp_pin_act_t'(cfg_reg[i][`TCP_CC_PIN_B:`TCP_CC_PIN_A]);

    tcp_channel u_ch (
      .pclk    (pclk),
      .presetn (presetn),
      .ch      (chif[i])
    );

    assign chan_pin_out[i] = chif[i].pin;
    assign chan_pin_oe[i]  = chif[i].pin_oe;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence wrap_hit_s;
    run && at_limit && !cnt_clear;
  endsequence

  wrap_restart_a : assert property (wrap_hit_s |=> cnt_reg == `TCP_CNT_ZERO)
    else $error("counter did not restart from zero at the limit");
  wrap_flag_a : assert property (wrap_hit_s |=> wrap_flag_reg)
    else $error("wrap flag not set at the limit");
  count_step_a : assert property (run && !at_limit && !cnt_clear |=> cnt_reg == $past(cnt_reg) + `TCP_CNT_ONE)
    else $error("counter did not advance on a tick");
  ch0_flag_a : assert property (run && oc_en[0] |=> cnt_reg != $past(cmp_val[0]) || ch_flag_reg[0])
    else $error("compare flag not set at match");
  flag_hold_a : assert property (ch_flag_reg[1] && !(wr && at_off(paddr, ch_ctrl_off(1)) && ch_armed_reg[1])
                                 |=> ch_flag_reg[1])
    else $error("channel flag dropped without an armed clear");
  link_swap_a : assert property (linked && !link_on && wrap_ev |=> active_sel_reg == $past(last_sel_next))
    else $error("linked value set did not switch at wrap");
  link_hold_a : assert property (linked && !wrap_ev && !link_on |=> active_sel_reg == $past(active_sel_reg))
    else $error("linked value set changed away from wrap");
  ch1_release_a : assert property (linked |-> !chan_pin_oe[1] && !match[1])
    else $error("second channel active while linked");
endmodule

// ===== rtl/tcp_consts.svh
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

// Register offsets
`define TCP_OFF_TIMER      12'h000
`define TCP_OFF_COUNT      12'h004
`define TCP_OFF_LIMIT      12'h008
`define TCP_OFF_CH0_CTRL   12'h00c
`define TCP_OFF_CH0_VALUE  12'h010
`define TCP_OFF_CH1_CTRL   12'h014
`define TCP_OFF_CH1_VALUE  12'h018
`define TCP_OFF_STRIDE     12'h008

// Timer control fields
`define TCP_TC_FLAG        7
`define TCP_TC_IE          6
`define TCP_TC_HALT        5
`define TCP_TC_RST         4
`define TCP_TC_DIV_MSB     2
`define TCP_TC_DIV_LSB     0

// Channel control fields
`define TCP_CC_FLAG        7
`define TCP_CC_IE          6
`define TCP_CC_MODE_B      5
`define TCP_CC_MODE_A      4
`define TCP_CC_PIN_B       3
`define TCP_CC_PIN_A       2
`define TCP_CC_TOV         1
`define TCP_CC_MAX         0

// Encodings
`define TCP_MODE_OFF       2'h0
`define TCP_MODE_UNBUF     2'h1
`define TCP_MODE_BUF       2'h2
`define TCP_DIV_NONE       3'h7

// Reset values
`define TCP_RST_HALT       1'b1
`define TCP_RST_DIV        3'h0
`define TCP_RST_LIMIT      16'hffff
`define TCP_RST_VALUE      16'h0000
`define TCP_RST_CFG        7'h00
`define TCP_CNT_ZERO       16'h0000
`define TCP_CNT_ONE        16'h0001

`endif

// ===== rtl/tcp_pkg.sv
package tcp_pkg;

  typedef enum logic [1:0] {
    TCP_PIN_NONE,
    TCP_PIN_TOGGLE,
    TCP_PIN_CLEAR,
    TCP_PIN_SET
  } tcp_pin_act_t;

  typedef logic [15:0] tcp_count_t;
  typedef logic [6:0]  tcp_cfg_t;

endpackage

// ===== rtl/tcp_chan_if.sv
`timescale 1ns/1ps
interface tcp_chan_if;
  import tcp_pkg::*;
  logic         tick;
  logic         wrap;
  logic         match;
  logic         enable;
  logic         tov;
  logic         fmax;
  tcp_pin_act_t act;
  logic         pin;
  logic         pin_oe;

  modport ctl (output tick, output wrap, output match, output enable, output tov, output fmax, output act,
               input pin, input pin_oe);
  modport chn (input tick, input wrap, input match, input enable, input tov, input fmax, input act,
               output pin, output pin_oe);
endinterface

// ===== rtl/tcp_prescaler.sv
`timescale 1ns/1ps
module tcp_prescaler
  import tcp_pkg::*;
#(
  parameter int DIV_BITS = 6
)(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic [2:0] sel,
  output logic            tick
);
  `include "tcp_consts.svh"

  if (DIV_BITS < 6) begin : g_chk
    $error("tcp_prescaler: DIV_BITS must be at least 6");
  end

  logic [DIV_BITS-1:0] div_reg;

  function automatic logic [DIV_BITS-1:0] div_mask(input logic [2:0] s);
    div_mask = DIV_BITS'((1 << s) - 1);
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= '0;
    else if (clear)
      div_reg <= '0;
    else
      div_reg <= div_reg + DIV_BITS'(1);
  end

  // Divide by 1..64, code 7 gives no tick
  assign tick = !clear && (sel != `TCP_DIV_NONE) &&
                ((div_reg & div_mask(sel)) == div_mask(sel));

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  div_two_a : assert property ((sel == 3'h1) && tick |=> !tick || (sel != 3'h1) || $past(clear))
    else $error("divide by two ticked twice in a row");
  div_none_a : assert property ((sel == `TCP_DIV_NONE) |-> !tick)
    else $error("unavailable divider code produced a tick");
endmodule

// ===== rtl/tcp_channel.sv
`timescale 1ns/1ps
module tcp_channel
  import tcp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  tcp_chan_if.chn   ch
);
  `include "tcp_consts.svh"

  logic pin_reg;
  logic pulse_level;
  logic full_duty;
  logic after_match;
  logic pin_next;

  assign pulse_level = (ch.act == TCP_PIN_SET) ? 1'b0 : 1'b1;
  assign full_duty   = ch.enable && ch.fmax && ch.tov;

  always_comb
  begin
    after_match = pin_reg;
    if (ch.match)
    begin
      unique case (ch.act)
        TCP_PIN_NONE:   after_match = pin_reg;
        TCP_PIN_TOGGLE: after_match = ~pin_reg;
        TCP_PIN_CLEAR:  after_match = 1'b0;
        TCP_PIN_SET:    after_match = 1'b1;
      endcase
    end
    pin_next = after_match;
    if (ch.wrap && ch.tov)
      pin_next = ~after_match;
  end

  // Compare drives the inactive level, wrap toggles back to the pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_reg <= 1'b0;
    else if (full_duty)
      pin_reg <= pulse_level;
    else if (ch.enable && ch.tick)
      pin_reg <= pin_next;
  end

  assign ch.pin    = pin_reg;
  assign ch.pin_oe = ch.enable;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  full_duty_a : assert property (full_duty |=> pin_reg == $past(pulse_level))
    else $error("full duty did not hold the pulse level");
  clear_match_a : assert property (ch.enable && !full_duty && ch.match && ch.act == TCP_PIN_CLEAR && !ch.wrap
                                   |=> !pin_reg)
    else $error("clear on compare left the pin high");
  set_match_a : assert property (ch.enable && !full_duty && ch.match && ch.act == TCP_PIN_SET && !ch.wrap
                                 |=> pin_reg)
    else $error("set on compare left the pin low");
  wrap_toggle_a : assert property (ch.enable && !full_duty && ch.wrap && ch.tov && !ch.match
                                   |=> pin_reg != $past(pin_reg))
    else $error("pin did not toggle at wrap");
  zero_duty_a : assert property (ch.enable && !ch.tov && ch.act == TCP_PIN_CLEAR && !pin_reg
                                 |=> !pin_reg)
    else $error("zero duty output went high");
endmodule

// ===== tb/tcp_pin_watch.sv
`timescale 1ns/1ps
module tcp_pin_watch (
  input  wire logic pclk,
  input  wire logic pin,
  input  wire logic oe,
  output int        period,
  output int        high_time
);
  logic lvl;
  logic prev = 1'b0;
  int   cnt;

  // Pulled-down line, reads low while undriven
  assign lvl = oe & pin;

  // Rise-to-rise period and rise-to-fall width in pclk cycles
  always @(posedge pclk)
  begin
    prev <= lvl;
    cnt  <= (lvl && !prev) ? 1 : cnt + 1;
    if (lvl && !prev)
      period <= cnt;
    if (!lvl && prev)
      high_time <= cnt;
  end
endmodule

// ===== tb/timer_compare_pwm_channels_bench.sv
`timescale 1ns/1ps
module timer_compare_pwm_channels_bench;
  import tcp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  chan_pin_out;
  logic [1:0]  chan_pin_oe;
  logic [1:0]  chan_irq;
  logic        wrap_irq;
  int          period [2];
  int          high_time [2];
  int          n_mismatch;
  int          checked;
  logic [31:0] rd;
  logic        err;
  int          lim;
  int          val;
  int          old_val;
  int          dv;

  tcp_top DUT (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .chan_pin_out (chan_pin_out),
    .chan_pin_oe  (chan_pin_oe),
    .chan_irq     (chan_irq),
    .wrap_irq     (wrap_irq)
  );

  tcp_pin_watch watch0 (.pclk(pclk), .pin(chan_pin_out[0]), .oe(chan_pin_oe[0]),
                        .period(period[0]), .high_time(high_time[0]));
  tcp_pin_watch watch1 (.pclk(pclk), .pin(chan_pin_out[1]), .oe(chan_pin_oe[1]),
                        .period(period[1]), .high_time(high_time[1]));

  function automatic int exp_period(input int limit, input int div);
    return (limit + 1) << div;
  endfunction

  function automatic int exp_high(input int value, input int div);
    return value << div;
  endfunction

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n == 16)
      check(32'h0000_0000, 32'h0000_0001, "pready timeout");
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic start_pwm(input int ch, input int limit, input int value, input logic [7:0] ctrl,
                           input int div);
    apb(12'h000, 1'b1, 32'h0000_0030);
    apb(12'h008, 1'b1, 32'(limit));
    apb(ch != 0 ? 12'h018 : 12'h010, 1'b1, 32'(value));
    apb(ch != 0 ? 12'h014 : 12'h00c, 1'b1, 32'(ctrl));
    apb(12'h000, 1'b1, 32'h0000_0040 | 32'(div));
  endtask

  task automatic check_pwm(input int ch, input int limit, input int high, input int div);
    repeat (4 * exp_period(limit, div) + 8) @(posedge pclk);
    check(period[ch], exp_period(limit, div), "period");
    check(high_time[ch], exp_high(high, div), "width");
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    #1_000_000;
    n_mismatch++;
    print_verdict;
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'hf4ba8a52));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state and unmapped access
    apb(12'h008, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_ffff, "limit reset");
    apb(12'h000, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0020, "timer ctrl reset");
    apb(12'h01c, 1'b1, 32'hffff_ffff);
    check(err, 1'b1, "unmapped write error");
    apb(12'h01c, 1'b0, 32'h0000_0000);
    check(err, 1'b1, "unmapped read error");
    check(rd, 32'h0000_0000, "unmapped read data");
    // Documented 8-bit half duty
    start_pwm(0, 32'h0000_00ff, 32'h0000_0080, 8'h1a, 0);
    check_pwm(0, 255, 128, 0);
    apb(12'h000, 1'b0, 32'h0000_0000);
    check({rd[7], wrap_irq}, 2'b11, "wrap flag");
    apb(12'h00c, 1'b0, 32'h0000_0000);
    check({rd[7], chan_irq[0]}, 2'b10, "masked compare");
    apb(12'h00c, 1'b1, 32'h0000_005a);
    repeat (300) @(posedge pclk);
    check(chan_irq, 2'b01, "compare request");
    // Set on compare gives a low pulse
    start_pwm(0, 63, 16, 8'h1e, 0);
    check_pwm(0, 63, 48, 0);
    // Every divider code
    for (dv = 0; dv < 7; dv++)
    begin
      start_pwm(0, 7, 3, 8'h1a, dv);
      check_pwm(0, 7, 3, dv);
    end
    start_pwm(0, 7, 3, 8'h1a, 7);
    repeat (50) @(posedge pclk);
    apb(12'h004, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000, "count held");
    // Zero then full duty
    for (dv = 0; dv < 2; dv++)
    begin
      start_pwm(0, 63, 16, dv != 0 ? 8'h1b : 8'h18, 0);
      repeat (200) @(posedge pclk);
      repeat (64)
      begin
        @(posedge pclk);
        #1;
        check(chan_pin_out[0], dv[0], "fixed duty");
      end
    end
    // Linked pair
    start_pwm(0, 63, 16, 8'h2a, 0);
    check(chan_pin_oe, 2'b01, "linked enables");
    check_pwm(0, 63, 16, 0);
    apb(12'h018, 1'b1, 32'h0000_0020);
    check_pwm(0, 63, 32, 0);
    apb(12'h014, 1'b1, 32'h0000_001a);
    #1;
    check(chan_pin_oe, 2'b01, "second ctrl ignored");
    apb(12'h010, 1'b1, 32'h0000_0008);
    check_pwm(0, 63, 8, 0);
    apb(12'h00c, 1'b1, 32'h0000_0000);
    // Random unbuffered duty on the second channel
    repeat (4)
    begin
      lim = 16 + $urandom_range(0, 100);
      val = $urandom_range(1, lim);
      dv = $urandom_range(0, 2);
      start_pwm(1, lim, val, 8'h1a, dv);
      check(chan_pin_oe[1], 1'b1, "unbuffered enable");
      check_pwm(1, lim, val, dv);
      old_val = val;
      val = $urandom_range(1, lim);
      if (val < old_val)
        @(negedge chan_pin_out[1]);
      else
        @(posedge chan_pin_out[1]);
      apb(12'h018, 1'b1, 32'(val));
      check_pwm(1, lim, val, dv);
    end
    print_verdict;
  end
endmodule
